// file: rtl/rxq_cfg_top.sv
// receive equalizer boost, acquisition loop override and jitter
// loss-of-lock threshold bank behind an avalon-mm slave.
// assumes a single 50 mhz clock and synchronous inputs.
//
// Summary of operation
// - bits 7:5 of the boost register pick 0 to 7 dB of boost in 1 dB steps.
// - override bit 1 selects the written 7-bit loop value, 0 the internal.
// - loop filter readback need not equal the last value written.
// - writing 1 to bit 7 with index 4 in bits 5:0 of the index register applies, then self-clears.
// - threshold is 14-bit unsigned, bit 0 in bit 7 of the first data reg.
// - threshold bits 8:1 sit in bits 7:0 of the second data register.
// - loss of lock asserts above and deasserts below the threshold.
// - threshold bits 13:9 sit in bits 4:0 of the third data register.
`timescale 1ns/1ps
`default_nettype none
`include "rxq_regs.svh"

module rxq_cfg_top import rxq_pkg::*; #(
   parameter int ADDR_W = 10
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // receive path
   input wire logic [6:0] acq_filter_internal_i,
   input wire logic [`RXQ_THRESH_W-1:0] jitter_measure_i,
   output logic [2:0] eq_high_freq_gain_sel_o,
   output logic acq_filter_override_en_o,
   output logic [6:0] acq_filter_value_o,
   output logic [`RXQ_THRESH_W-1:0] jitter_lock_threshold_o,
   output logic rx_loss_of_lock_o
);

   // highest index 0x72 needs nine byte-address bits
   if (ADDR_W < 9) begin : g_addr_chk
      $error("rxq_cfg_top: ADDR_W must be at least 9");
   end
   // header width and packed threshold struct must agree
   if (`RXQ_THRESH_W != $bits(rxq_thresh_t)) begin : g_thr_chk
      $error("rxq_cfg_top: threshold width mismatch");
   end

   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
      logic [ADDR_W-1:0] want;
      want = ADDR_W'({idx, 2'b00});
      reg_hit = (addr == want);
   endfunction : reg_hit

   // register slots in select order; one decode serves both paths
   localparam int NSLOT = 9;
   localparam int S_EQ = 0;
   localparam int S_ACQ = 1;
   localparam int S_CTL = 2;
   localparam int S_LOW = 3;
   localparam int S_MID = 4;
   localparam int S_HIGH = 5;
   localparam int S_STAT = 6;
   localparam int S_APLO = 7;
   localparam int S_APHI = 8;
   localparam logic [7:0] SLOT_IDX [NSLOT] = '{
      `RXQ_IDX_EQ_BOOST,
      `RXQ_IDX_ACQ_FILT,
      `RXQ_IDX_THR_CTL,
      `RXQ_IDX_THR_LOW,
      `RXQ_IDX_THR_MID,
      `RXQ_IDX_THR_HIGH,
      `RXQ_IDX_LOCK_STAT,
      `RXQ_IDX_THR_APP_LO,
      `RXQ_IDX_THR_APP_HI
   };

   // bus handshake
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_fire;
   logic [NSLOT-1:0] sel;
   logic [NSLOT-1:0] we;

   // configuration state
   logic [7:0] eq_q, eq_d;
   rxq_acq_t acq_q, acq_d;
   rxq_idx_t idx_q, idx_d;
   logic [7:0] tlo_q, tlo_d;
   logic [7:0] tmid_q, tmid_d;
   logic [7:0] thi_q, thi_d;
   rxq_thresh_t thr_q, thr_d;
   logic [6:0] filt_q, filt_d;
   logic lol;

   // waitrequest low for exactly one cycle per request
   always_comb begin
      wait_d = 1'b1;
      if ((avs_read_i || avs_write_i) && wait_q) begin
         wait_d = 1'b0;
      end
   end

   // write lands only on the edge the master sees waitrequest low;
   // data lives in lane 0, other lanes are dropped
   assign wr_fire = avs_write_i && !wait_q && avs_byteenable_i[0];

   // full address match per slot, so stray offsets never alias
   for (genvar g = 0; g < NSLOT; g++) begin : g_slot
      assign sel[g] = reg_hit(avs_address_i, SLOT_IDX[g]);
      assign we[g] = wr_fire && sel[g];
   end

   always_comb begin
      rdata_d = rdata_q;
      if (avs_read_i && wait_q) begin
         rdata_d = 32'h0000_0000;
         if (sel[S_EQ]) begin
            rdata_d[7:0] = eq_q;
         end else if (sel[S_ACQ]) begin
            // shows the value in use, not the one written
            rdata_d[7:0] = {acq_q.override_en, filt_q};
         end else if (sel[S_CTL]) begin
            rdata_d[7:0] = idx_q;
         end else if (sel[S_LOW]) begin
            rdata_d[7:0] = tlo_q;
         end else if (sel[S_MID]) begin
            rdata_d[7:0] = tmid_q;
         end else if (sel[S_HIGH]) begin
            rdata_d[7:0] = thi_q;
         end else if (sel[S_STAT]) begin
            rdata_d[0] = lol;
         end else if (sel[S_APLO]) begin
            rdata_d[7:0] = thr_q[7:0];
         end else if (sel[S_APHI]) begin
            rdata_d[5:0] = thr_q[13:8];
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // equalizer and loop filter registers
   always_comb begin
      eq_d = eq_q;
      acq_d = acq_q;
      if (we[S_EQ]) begin
         // boost code kept with its low bits as written
         eq_d = avs_writedata_i[7:0];
      end
      if (we[S_ACQ]) begin
         acq_d = avs_writedata_i[7:0];
      end
   end

   always_comb begin
      if (acq_q.override_en) begin
         filt_d = acq_q.value;
      end else begin
         filt_d = acq_filter_internal_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         eq_q <= `RXQ_RST_EQ_BOOST;
         acq_q <= `RXQ_RST_ACQ_FILT;
         filt_q <= `RXQ_RST_FILT;
      end else begin
         eq_q <= eq_d;
         acq_q <= acq_d;
         filt_q <= filt_d;
      end
   end

   // threshold index control and data registers
   always_comb begin
      idx_d = idx_q;
      // apply strobe clears itself one cycle later
      idx_d.apply = 1'b0;
      tlo_d = tlo_q;
      tmid_d = tmid_q;
      thi_d = thi_q;
      // a fresh write wins over the self-clear
      if (we[S_CTL]) begin
         idx_d = avs_writedata_i[7:0];
      end
      if (we[S_LOW]) begin
         tlo_d = avs_writedata_i[7:0];
      end
      if (we[S_MID]) begin
         tmid_d = avs_writedata_i[7:0];
      end
      if (we[S_HIGH]) begin
         thi_d = avs_writedata_i[7:0];
      end
   end

   always_comb begin
      thr_d = thr_q;
      // apply copies data only at the threshold address
      if (idx_q.apply && idx_q.index == `RXQ_THRESH_INDEX) begin
         // lsb from bit 7 of the first register
         thr_d.lo = tlo_q[`RXQ_THR_LOW_BIT];
         // bits 8:1 from the second register
         thr_d.mid = tmid_q;
         // bits 13:9 from the third register
         thr_d.hi = thi_q[`RXQ_THR_HIGH_MSB:0];
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         idx_q <= `RXQ_RST_THR_CTL;
         tlo_q <= `RXQ_RST_THR_LOW;
         tmid_q <= `RXQ_RST_THR_MID;
         thi_q <= `RXQ_RST_THR_HIGH;
         thr_q <= `RXQ_RST_THRESH;
      end else begin
         idx_q <= idx_d;
         tlo_q <= tlo_d;
         tmid_q <= tmid_d;
         thi_q <= thi_d;
         thr_q <= thr_d;
      end
   end

   // compare against the applied threshold only
   rxq_lol_det #(
      .W(`RXQ_THRESH_W)
   ) u_lol_det (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .measure_i(jitter_measure_i),
      .thresh_i(thr_q),
      .lol_o(lol)
   );

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   // boost code drives the equalizer directly
   assign eq_high_freq_gain_sel_o = eq_q[`RXQ_EQ_GAIN_MSB:`RXQ_EQ_GAIN_LSB];
   assign acq_filter_override_en_o = acq_q.override_en;
   assign acq_filter_value_o = filt_q;
   assign jitter_lock_threshold_o = thr_q;
   assign rx_loss_of_lock_o = lol;

endmodule : rxq_cfg_top

`default_nettype wire

// file: rtl/rxq_regs.svh
// register indices, field positions, reset values and apply settings
// for the receive equalizer, acquisition loop and lock threshold bank.
// assumes byte address = 4 * index on a 32-bit slave.
`ifndef RXQ_REGS_SVH
`define RXQ_REGS_SVH

`define RXQ_IDX_EQ_BOOST 8'h55
`define RXQ_IDX_ACQ_FILT 8'h62
`define RXQ_IDX_THR_CTL 8'h6a
`define RXQ_IDX_THR_LOW 8'h6b
`define RXQ_IDX_THR_MID 8'h6c
`define RXQ_IDX_THR_HIGH 8'h6d
`define RXQ_IDX_LOCK_STAT 8'h70
`define RXQ_IDX_THR_APP_LO 8'h71
`define RXQ_IDX_THR_APP_HI 8'h72

`define RXQ_EQ_GAIN_MSB 7
`define RXQ_EQ_GAIN_LSB 5
`define RXQ_THR_LOW_BIT 7
`define RXQ_THR_HIGH_MSB 4

`define RXQ_RST_EQ_BOOST 8'h00
`define RXQ_RST_ACQ_FILT 8'h1e
`define RXQ_RST_THR_CTL 8'h00
`define RXQ_RST_THR_LOW 8'h00
`define RXQ_RST_THR_MID 8'h00
`define RXQ_RST_THR_HIGH 8'h00
`define RXQ_RST_THRESH 14'h0000
`define RXQ_RST_FILT 7'h00

`define RXQ_THRESH_INDEX 6'h04
`define RXQ_THRESH_W 14

`endif

// file: rtl/rxq_pkg.sv
// types shared by the receive configuration bank and its detector.
// assumes rxq_regs.svh supplies the numeric constants.
package rxq_pkg;

   // applied threshold: {13:9, 8:1, 0}
   typedef struct packed {
      logic [4:0] hi;
      logic [7:0] mid;
      logic lo;
   } rxq_thresh_t;

   typedef struct packed {
      logic override_en;
      logic [6:0] value;
   } rxq_acq_t;

   typedef struct packed {
      logic apply;
      logic rsvd;
      logic [5:0] index;
   } rxq_idx_t;

endpackage : rxq_pkg

// file: rtl/rxq_lol_det.sv
// loss-of-lock comparator with hold on equality.
// assumes measure and threshold are synchronous unsigned values.
`timescale 1ns/1ps
`default_nettype none

module rxq_lol_det #(
   parameter int W = 14
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] measure_i,
   input wire logic [W-1:0] thresh_i,
   output logic lol_o
);

   if (W < 1) begin : g_w_chk
      $error("rxq_lol_det: width must be at least 1");
   end

   logic lol_q, lol_d;

   always_comb begin
      lol_d = lol_q;
      if (measure_i > thresh_i) begin
         lol_d = 1'b1;
      end else if (measure_i < thresh_i) begin
         lol_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lol_q <= 1'b0;
      end else begin
         lol_q <= lol_d;
      end
   end

   assign lol_o = lol_q;

endmodule : rxq_lol_det

`default_nettype wire

// file: dv/rxq_cfg_asserts.sv
// port assertions for the receive configuration bank.
// assumes one clock and register byte address of 4 * index.
`timescale 1ns/1ps
`default_nettype none
module rxq_cfg_asserts #(
   parameter int ADDR_W = 10
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic [6:0] acq_filter_internal_i,
   input wire logic [13:0] jitter_measure_i,
   input wire logic [2:0] eq_high_freq_gain_sel_o,
   input wire logic acq_filter_override_en_o,
   input wire logic [6:0] acq_filter_value_o,
   input wire logic [13:0] jitter_lock_threshold_o,
   input wire logic rx_loss_of_lock_o
);
   logic req;
   logic wr_ok;
   logic ap;
   assign req = avs_read_i || avs_write_i;
   assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign ap = wr_ok && avs_address_i == 10'h1a8 && avs_writedata_i[7]
      && avs_writedata_i[5:0] == 6'h04;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_new;
      req && !$past(req);
   endsequence
   sequence s_low;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_bus_answer: assert property (s_new |-> ##[1:2] s_low)
      else $error("bus answer late");
   a_lol_rise: assert property (
      jitter_measure_i > jitter_lock_threshold_o |=> rx_loss_of_lock_o)
      else $error("lock loss not raised");
   a_lol_fall: assert property (
      jitter_measure_i < jitter_lock_threshold_o |=> !rx_loss_of_lock_o)
      else $error("lock loss not cleared");
   a_lol_hold: assert property (
      jitter_measure_i == jitter_lock_threshold_o
      |=> $stable(rx_loss_of_lock_o))
      else $error("lock loss moved on equality");
   a_acq_internal: assert property (!acq_filter_override_en_o
      |=> acq_filter_value_o == $past(acq_filter_internal_i))
      else $error("internal loop value not used");
   a_ovr_value: assert property (
      wr_ok && avs_address_i == 10'h188
      |=> acq_filter_override_en_o == $past(avs_writedata_i[7]))
      else $error("override bit wrong");
   a_eq_value: assert property (
      wr_ok && avs_address_i == 10'h154
      |=> eq_high_freq_gain_sel_o == $past(avs_writedata_i[7:5]))
      else $error("boost code wrong");
   a_thr_source: assert property (
      !$stable(jitter_lock_threshold_o) |-> $past(ap) || $past(ap, 2))
      else $error("threshold moved without apply");
endmodule : rxq_cfg_asserts
bind rxq_cfg_top rxq_cfg_asserts #(.ADDR_W(ADDR_W)) i_rxq_cfg_asserts (.*);
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the receive configuration bank.
// assumes rxq_cfg_top with its checker bound in.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [9:0] avs_address_i = 10'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'h1;
   logic [6:0] acq_filter_internal_i = 7'h0;
   logic [13:0] jitter_measure_i = 14'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic acq_filter_override_en_o;
   logic rx_loss_of_lock_o;
   logic [6:0] acq_filter_value_o;
   logic [13:0] jitter_lock_threshold_o;
   logic [13:0] t;
   logic [2:0] eq_high_freq_gain_sel_o;
   logic [31:0] q[$];
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   int dm[4] = '{1, 0, -1, 0};
   logic le[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0] ri[6] = '{8'h55, 8'h6a, 8'h6b, 8'h6c, 8'h6d, 8'h60};
   rxq_cfg_top i_rxq_cfg_top (.*);
   initial begin
      forever #10 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // request held until waitrequest is seen low at a rising edge
   task automatic bus(logic w, logic [7:0] x, logic [7:0] d);
      @(posedge ref_clk_i);
      avs_address_i <= {x, 2'h0};
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= {24'($urandom), d};
      do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic rd(logic [7:0] x, logic [7:0] e);
      q.push_back({24'h0, e});
      bus(1'b0, x, 8'h0);
   endtask : rd
   task automatic settle;
      repeat (2) @(negedge ref_clk_i);
   endtask : settle
   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   always @(posedge ref_clk_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0 && q.size() > 0)
         chk("readdata", avs_readdata_o, q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         results();
      end
   end
   initial begin
      void'($urandom(6));
      acq_filter_internal_i <= 7'($urandom);
      repeat (10) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (ri[i]) rd(ri[i], 8'h00);
      rd(8'h62, {1'b0, acq_filter_internal_i});
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, 8'h55, {3'(c), 5'h0});
         settle();
         chk("eq_sel", 32'(eq_high_freq_gain_sel_o), 32'(c));
      end
      @(posedge ref_clk_i);
      avs_byteenable_i <= 4'he;
      bus(1'b1, 8'h55, 8'h00);
      avs_byteenable_i <= 4'h1;
      settle();
      chk("eq_sel", 32'(eq_high_freq_gain_sel_o), 32'h7);
      for (int k = 0; k < 3; k++) begin
         t = (k == 0) ? 14'h3fff : 14'($urandom_range(1, 16382));
         bus(1'b1, 8'h6a, 8'h04);
         bus(1'b1, 8'h6b, {t[0], 7'h20});
         bus(1'b1, 8'h6c, t[8:1]);
         bus(1'b1, 8'h6d, {3'h5, t[13:9]});
         bus(1'b1, 8'h6a, 8'h84);
         settle();
         chk("thresh", 32'(jitter_lock_threshold_o), 32'(t));
         rd(8'h6a, 8'h04);
         rd(8'h71, t[7:0]);
         rd(8'h72, {2'h0, t[13:8]});
      end
      // a data write without the strobe leaves the threshold alone
      bus(1'b1, 8'h6c, ~t[8:1]);
      settle();
      chk("thresh", 32'(jitter_lock_threshold_o), 32'(t));
      // loss of lock first, then the loop override
      @(posedge ref_clk_i);
      jitter_measure_i <= 14'($urandom_range(16383, 32'(t) + 32'd1));
      settle();
      chk("lol", 32'(rx_loss_of_lock_o), 32'h1);
      bus(1'b1, 8'h62, 8'h98);
      settle();
      chk("ovr", 32'(acq_filter_override_en_o), 32'h1);
      chk("acq", 32'(acq_filter_value_o), 32'h18);
      @(posedge ref_clk_i);
      jitter_measure_i <= 14'h0;
      acq_filter_internal_i <= 7'($urandom);
      settle();
      chk("lol", 32'(rx_loss_of_lock_o), 32'h0);
      bus(1'b1, 8'h62, 8'h00);
      settle();
      chk("ovr", 32'(acq_filter_override_en_o), 32'h0);
      chk("acq", 32'(acq_filter_value_o), 32'(acq_filter_internal_i));
      rd(8'h62, {1'b0, acq_filter_internal_i});
      foreach (dm[i]) begin
         @(posedge ref_clk_i);
         jitter_measure_i <= 14'(t + dm[i]);
         settle();
         chk("lol", 32'(rx_loss_of_lock_o), 32'(le[i]));
         rd(8'h70, {7'h0, le[i]});
      end
      results();
   end
endmodule : testbench
`default_nettype wire
